/* File: tb/bars_breaker_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bars_breaker_model (
	input wire logic pclk,
	input wire logic close_cmd,
	input wire logic trip_req,
	input wire logic man_req,
	input wire logic permit,
	input wire logic block,
	output bars_pkg::bars_pins_t pins
);
	import bars_pkg::*;
	logic closed_q = 1'b0;
	// Contacts lag the coil by a cycle, so close_cmd is seen before closed
	always @(posedge pclk) begin
		if (trip_req)
			closed_q <= 1'b0;
		else if (close_cmd || man_req)
			closed_q <= 1'b1;
	end
	assign pins = '{trip_req, closed_q, man_req, permit, block};
endmodule : bars_breaker_model
`default_nettype wire

/* File: tb/breaker_autoreclose_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module breaker_autoreclose_sequencer_bench;
	import bars_pkg::*;
	localparam int CL = 4;
	localparam int RDY = 3;
	localparam int LCK = 2;
	localparam int BSY = 1;
	localparam int BLK = 0;
	localparam int PT = 0;
	localparam int PM = 1;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic trip = 1'b0;
	logic man = 1'b0;
	logic permit = 1'b0;
	logic blk = 1'b0;
	bars_pins_t pins;
	bars_cmd_t cmd_out;
	logic [31:0] rd;
	logic err;
	int fails = 0;
	int checks_done = 0;
	always #50 pclk = ~pclk;
	bars_sequencer #(.TICK_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pins_in(pins), .cmd_out(cmd_out));
	bars_breaker_model brk (.pclk(pclk), .close_cmd(cmd_out.close_cmd), .trip_req(trip),
		.man_req(man), .permit(permit), .block(blk), .pins(pins));
	task automatic close_out;
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out
	task automatic chk(input logic ok, input string m);
		checks_done++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : chk
	// Held until pready is sampled high; no fixed wait-state count assumed
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic wcmd(input int b, input int lim, input string m);
		int n;
		n = 0;
		while (cmd_out[b] !== 1'b1 && n < lim) begin
			@(posedge pclk);
			n++;
		end
		chk(cmd_out[b] === 1'b1, m);
	endtask : wcmd
	// Pin chosen by code; a ref argument cannot take a non-blocking write
	task automatic pulse(input int w);
		if (w == PT) trip <= 1'b1;
		else man <= 1'b1;
		repeat (4) @(posedge pclk);
		if (w == PT) trip <= 1'b0;
		else man <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : pulse
	task automatic s_reset;
		chk(cmd_out === 5'b00100, "reset outputs");
		apb(1'b0, 8'h00, 32'h0);
		chk(rd === 32'h00000010 && err === 1'b0, "ctrl reset");
		apb(1'b0, 8'h24, 32'h0);
		chk(err === 1'b1, "unmapped read");
		apb(1'b1, 8'h00, 32'h00000021);
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h08, 32'h2);
		apb(1'b1, 8'h14, 32'h000FFFFF);
		apb(1'b0, 8'h14, 32'h0);
		chk(rd === 32'h00015F90, "time not capped at 900 s");
		apb(1'b1, 8'h14, 32'h3);
		apb(1'b1, 8'h18, 32'h14);
		apb(1'b1, 8'h1C, 32'h5);
	endtask : s_reset
	task automatic s_manual;
		pulse(PM);
		chk(cmd_out[RDY] === 1'b0 && cmd_out[LCK] === 1'b0, "ready too early");
		wcmd(RDY, 60, "no ready after reclaim");
	endtask : s_manual
	task automatic s_shots;
		trip <= 1'b1;
		wcmd(CL, 8, "zero dead time not immediate");
		trip <= 1'b0;
		// Contacts and synchroniser need four edges before settle shows
		repeat (6) @(posedge pclk);
		chk(cmd_out[BSY] === 1'b1 && cmd_out[CL] === 1'b0, "not settling");
		pulse(PT);
		wcmd(CL, 60, "second shot missing");
		apb(1'b0, 8'h20, 32'h0);
		chk(rd[6:5] === 2'd1, "shot index");
		repeat (4) @(posedge pclk);
		pulse(PT);
		wcmd(LCK, 20, "no lockout after last shot");
		chk(cmd_out[CL] === 1'b0, "close in lockout");
	endtask : s_shots
	task automatic s_settle;
		s_manual();
		pulse(PT);
		wcmd(CL, 20, "close missing");
		repeat (4) @(posedge pclk);
		chk(cmd_out[RDY] === 1'b0, "ready before reset time");
		wcmd(RDY, 60, "no ready after reset time");
	endtask : s_settle
	task automatic s_reclaim_trip;
		pulse(PT);
		wcmd(CL, 20, "close missing");
		repeat (4) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h00000010);
		wcmd(LCK, 10, "enable off");
		apb(1'b1, 8'h00, 32'h00000023);
		pulse(PM);
		pulse(PT);
		wcmd(LCK, 10, "trip in reclaim");
	endtask : s_reclaim_trip
	task automatic s_permit;
		s_manual();
		pulse(PT);
		wcmd(LCK, 200, "hold expiry");
		chk(cmd_out[CL] === 1'b0, "close without permit");
		s_manual();
		pulse(PT);
		repeat (30) @(posedge pclk);
		chk(cmd_out[CL] === 1'b0 && cmd_out[BSY] === 1'b1, "closed early");
		permit <= 1'b1;
		wcmd(CL, 10, "permit close");
	endtask : s_permit
	task automatic s_block;
		repeat (3) @(posedge pclk);
		blk <= 1'b1;
		wcmd(BLK, 6, "block");
		chk(cmd_out[CL] === 1'b0 && cmd_out[BSY] === 1'b0, "runs while blocked");
		pulse(PT);
		chk(cmd_out[BLK] === 1'b1, "trip while blocked");
		blk <= 1'b0;
		wcmd(LCK, 6, "release");
		pulse(PT);
		chk(cmd_out[LCK] === 1'b1, "trip left lockout");
		pulse(PM);
		chk(cmd_out[LCK] === 1'b0, "manual close");
	endtask : s_block
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		@(posedge pclk);
		s_reset();
		s_manual();
		s_shots();
		s_settle();
		s_reclaim_trip();
		s_permit();
		s_block();
		close_out();
	end
	// Scenarios need a few hundred cycles
	initial begin
		#3000000;
		fails++;
		close_out();
	end
endmodule : breaker_autoreclose_sequencer_bench
`default_nettype wire

/* File: verilog/bars_pkg.sv */
package bars_pkg;
	typedef enum logic [3:0] {
		ST_LOCKOUT, ST_RECLAIM, ST_READY, ST_DEAD, ST_PERMIT, ST_CLOSING, ST_SETTLE, ST_BLOCKED
	} bars_state_t;
	typedef logic [16:0] bars_time_t;
	typedef struct packed {
		logic trip;
		logic closed;
		logic man_close;
		logic permit;
		logic block;
	} bars_pins_t;
	typedef struct packed {
		logic close_cmd;
		logic ready;
		logic lockout;
		logic busy;
		logic blocked;
	} bars_cmd_t;
endpackage : bars_pkg

/* File: verilog/bars_regs.svh */
// How it works
// (R1) Up to four reclose shots run in turn, each with its own dead time, then lockout.
// (R2) After a manual close the reclaim time must run out before the ready state.
// (R3) A new trip during the reclaim time sends the sequencer straight to lockout.
// (R4) After an automatic close the reset time must run out with no new trip before ready.
// (R5) A trip during the reset time moves on to the next shot and starts its dead time.
// (R6) A trip during the reset time of the last permitted shot gives lockout instead.
// (R7) With permission required, close is driven only while the permission input is high.
// (R8) With permission required, the hold time bounds the wait; expiry gives lockout.
// (R9) The block input stops reclosing at once, in any state or shot.
// (R10) Releasing the block gives lockout, left only by a manual close.
// (R11) The permission option is not required or required, not required after reset.
// (R12) Every timer counts 10 ms ticks from zero up to 900 s; zero expires at once.
`ifndef BARS_REGS_SVH
`define BARS_REGS_SVH
`define BARS_OFF_CTRL 8'h00
`define BARS_OFF_DEAD0 8'h04
`define BARS_OFF_DEAD3 8'h10
`define BARS_OFF_RECLAIM 8'h14
`define BARS_OFF_HOLD 8'h18
`define BARS_OFF_RESET 8'h1C
`define BARS_OFF_STATUS 8'h20
`define BARS_CTRL_EN 0
`define BARS_CTRL_PERMIT_REQUIRED 1
`define BARS_CTRL_LIM_LO 4
`define BARS_CTRL_LIM_HI 6
`define BARS_RST_EN 1'b0
`define BARS_RST_PERMIT_REQUIRED 1'b0
`define BARS_RST_LIM 3'h1
`define BARS_MAX_SHOTS 3'h4
`define BARS_TIME_W 17
`define BARS_RST_TIME 17'h00000
`define BARS_CLK_NS 100
`define BARS_TICK_MS 10
`define BARS_TICK_CYCLES ((`BARS_TICK_MS * 1000000) / `BARS_CLK_NS)
`define BARS_MAX_S 900
`define BARS_MAX_TICKS ((`BARS_MAX_S * 1000) / `BARS_TICK_MS)
`endif

/* File: verilog/bars_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bars_regs.svh"
module bars_sequencer #(
	parameter int TICK_CYCLES = `BARS_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire bars_pkg::bars_pins_t pins_in,
	output bars_pkg::bars_cmd_t cmd_out
);
	import bars_pkg::*;

	function automatic bars_time_t sat_time(input logic [31:0] v);
		sat_time = (v > `BARS_MAX_TICKS) ? bars_time_t'(`BARS_MAX_TICKS) : v[16:0];
	endfunction : sat_time

	function automatic logic [2:0] clamp_lim(input logic [2:0] v);
		clamp_lim = (v == 3'h0) ? 3'h1 : (v > `BARS_MAX_SHOTS) ? `BARS_MAX_SHOTS : v;
	endfunction : clamp_lim

	// Pin synchroniser, edge history taken from the second stage only
	bars_pins_t sync1_q, pin, prev_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_q <= '0;
			pin <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= pins_in;
			pin <= sync1_q;
			prev_q <= pin;
		end
	end
	wire trip_rise = pin.trip & ~prev_q.trip;
	wire man_rise = pin.man_close & ~prev_q.man_close;

	// APB slave: one wait state so that read data leave a register
	logic ready_q, slverr_q, en_q, permit_required_q;
	logic [31:0] rdata_q;
	logic [2:0] lim_q;
	bars_time_t reclaim_q, hold_q, reset_q, dead_rd, bus_dead;
	wire [5:0] idx = paddr[7:2];
	wire in_dead = paddr >= `BARS_OFF_DEAD0 && paddr <= `BARS_OFF_DEAD3;
	wire mapped = paddr[1:0] == 2'h0 && paddr <= `BARS_OFF_STATUS;
	wire acc_first = psel & penable & ~ready_q;
	wire wr = psel & penable & ready_q & pwrite & mapped;
	wire [1:0] wslot = 2'(idx - 6'h01);

	bars_state_t state_q, state_d;
	logic [1:0] shot_q, shot_d;
	logic fresh_q;
	bars_time_t tmr_q, tmr_d, tmr_ld;
	logic [16:0] tick_q;
	bars_cmd_t cmd_d, cmd_q;

	wire [1:0] last_shot = 2'(lim_q - 3'h1);
	wire expired = ~fresh_q && tmr_q == '0;
	wire tick = tick_q == 17'(TICK_CYCLES - 1);
	wire [31:0] status_word = {20'h00000, pin, shot_q, 1'b0, state_q};
	wire [31:0] rmux = (paddr == `BARS_OFF_CTRL) ? {25'h0, lim_q, 2'h0, permit_required_q, en_q} :
		in_dead ? {15'h0, bus_dead} :
		(paddr == `BARS_OFF_RECLAIM) ? {15'h0, reclaim_q} :
		(paddr == `BARS_OFF_HOLD) ? {15'h0, hold_q} :
		(paddr == `BARS_OFF_RESET) ? {15'h0, reset_q} :
		(paddr == `BARS_OFF_STATUS) ? status_word : 32'h00000000;

	// Dead times per shot, one word each [R1]
	bars_shot_mem #(.W(`BARS_TIME_W), .DEPTH(4)) u_dead (
		.clk(pclk),
		.rst_n(presetn),
		.we(wr & in_dead),
		.waddr(wslot),
		.wdata(sat_time(pwdata)),
		.raddr_a(shot_d),
		.rdata_a(dead_rd),
		.raddr_b(2'(idx - 6'h01)),
		.rdata_b(bus_dead)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_q <= 1'b0;
			slverr_q <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ready_q <= acc_first;
			slverr_q <= acc_first & ~mapped;
			if (acc_first) begin
				rdata_q <= mapped ? rmux : 32'h00000000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= `BARS_RST_EN;
			permit_required_q <= `BARS_RST_PERMIT_REQUIRED; // [R11]
			lim_q <= `BARS_RST_LIM;
			reclaim_q <= `BARS_RST_TIME;
			hold_q <= `BARS_RST_TIME;
			reset_q <= `BARS_RST_TIME;
		end else if (wr) begin
			if (paddr == `BARS_OFF_CTRL) begin
				en_q <= pwdata[`BARS_CTRL_EN];
				permit_required_q <= pwdata[`BARS_CTRL_PERMIT_REQUIRED]; // [R11]
				lim_q <= clamp_lim(pwdata[`BARS_CTRL_LIM_HI:`BARS_CTRL_LIM_LO]); // [R1]
			end
			if (paddr == `BARS_OFF_RECLAIM) reclaim_q <= sat_time(pwdata); // [R12]
			if (paddr == `BARS_OFF_HOLD) hold_q <= sat_time(pwdata); // [R12]
			if (paddr == `BARS_OFF_RESET) reset_q <= sat_time(pwdata); // [R12]
		end
	end

	// Next state; block outranks every other event except the enable being off
	always_comb begin
		state_d = state_q;
		shot_d = shot_q;
		if (!en_q) begin
			state_d = ST_LOCKOUT;
		end else if (pin.block) begin
			state_d = ST_BLOCKED; // [R9]
		end else begin
			case (state_q)
				ST_BLOCKED: state_d = ST_LOCKOUT; // [R10]
				ST_LOCKOUT: if (man_rise) state_d = ST_RECLAIM; // [R10]
				ST_RECLAIM: begin
					if (trip_rise) state_d = ST_LOCKOUT; // [R3]
					else if (expired) state_d = ST_READY; // [R2]
				end
				ST_READY: begin
					if (trip_rise) begin
						shot_d = 2'h0; // [R1]
						state_d = ST_DEAD;
					end
				end
				ST_DEAD: if (expired) state_d = permit_required_q ? ST_PERMIT : ST_CLOSING;
				ST_PERMIT: begin
					if (pin.permit) state_d = ST_CLOSING; // [R8]
					else if (expired) state_d = ST_LOCKOUT; // [R8]
				end
				ST_CLOSING: begin
					if (pin.closed) state_d = ST_SETTLE;
					else if (permit_required_q && !pin.permit) state_d = ST_PERMIT; // [R7]
				end
				ST_SETTLE: begin
					if (trip_rise && shot_q == last_shot) begin
						state_d = ST_LOCKOUT; // [R6]
					end else if (trip_rise) begin
						shot_d = shot_q + 2'h1; // [R5]
						state_d = ST_DEAD;
					end else if (expired) begin
						shot_d = 2'h0;
						state_d = ST_READY; // [R4]
					end
				end
				default: state_d = ST_LOCKOUT;
			endcase
		end
	end

	// Timer loads the cycle after entry, when the dead time of the new shot is out
	assign tmr_ld = (state_q == ST_DEAD) ? dead_rd : // [R1]
		(state_q == ST_PERMIT) ? hold_q :
		(state_q == ST_SETTLE) ? reset_q :
		(state_q == ST_RECLAIM) ? reclaim_q : bars_time_t'(0);
	assign tmr_d = fresh_q ? tmr_ld : (tick && tmr_q != '0) ? tmr_q - 17'h1 : tmr_q; // [R12]

	always_comb begin
		cmd_d.close_cmd = state_d == ST_CLOSING && (!permit_required_q || pin.permit); // [R7]
		cmd_d.ready = state_d == ST_READY;
		cmd_d.lockout = state_d == ST_LOCKOUT;
		cmd_d.busy = state_d inside {ST_DEAD, ST_PERMIT, ST_CLOSING, ST_SETTLE};
		cmd_d.blocked = state_d == ST_BLOCKED; // [R9]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_LOCKOUT;
			shot_q <= 2'h0;
			fresh_q <= 1'b0;
			tmr_q <= '0;
			tick_q <= '0;
			cmd_q <= '0;
		end else begin
			state_q <= state_d;
			shot_q <= shot_d;
			fresh_q <= state_d != state_q;
			tmr_q <= tmr_d;
			tick_q <= (fresh_q || tick) ? 17'h0 : tick_q + 17'h1; // [R12]
			cmd_q <= cmd_d;
		end
	end

	assign cmd_out = cmd_q;
	assign prdata = rdata_q;
	assign pready = ready_q;
	assign pslverr = slverr_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire live = en_q & ~pin.block;

	sequence s_zero_dead;
		(state_q == ST_DEAD && fresh_q && dead_rd == '0) ##1 live;
	endsequence

	chk_block_wins: assert property (en_q && pin.block |=> state_q == ST_BLOCKED && !cmd_out.close_cmd) // [R9]
		else $error("block did not stop the sequencer");
	chk_block_release: assert property (state_q == ST_BLOCKED && live |=> state_q == ST_LOCKOUT) // [R10]
		else $error("block release did not give lockout");
	chk_lockout_hold: assert property (state_q == ST_LOCKOUT && !man_rise |=> state_q inside {ST_LOCKOUT, ST_BLOCKED}) // [R10]
		else $error("lockout left without manual close");
	chk_close_permit: assert property (cmd_out.close_cmd && permit_required_q |-> $past(pin.permit)) // [R7]
		else $error("close driven without permission");
	chk_reclaim_trip: assert property (state_q == ST_RECLAIM && trip_rise && live |=> state_q == ST_LOCKOUT) // [R3]
		else $error("trip in reclaim did not lock out");
	chk_reclaim_done: assert property (state_q == ST_RECLAIM && expired && !trip_rise && live |=> cmd_out.ready) // [R2]
		else $error("reclaim expiry did not give ready");
	chk_last_shot: assert property (state_q == ST_SETTLE && trip_rise && shot_q == last_shot && live |=> state_q == ST_LOCKOUT) // [R6]
		else $error("last shot did not lock out");
	chk_next_shot: assert property (state_q == ST_SETTLE && trip_rise && shot_q != last_shot && live |=> state_q == ST_DEAD ##0 shot_q == $past(shot_q) + 2'h1) // [R5]
		else $error("shot did not advance");
	chk_settle_ready: assert property (state_q == ST_SETTLE && expired && !trip_rise && live |=> state_q == ST_READY && shot_q == 2'h0) // [R4]
		else $error("reset time expiry did not give ready");
	chk_permit_limit: assert property (state_q == ST_PERMIT && expired && !pin.permit && live |=> state_q == ST_LOCKOUT) // [R8]
		else $error("hold time expiry did not lock out");
	chk_dead_load: assert property (state_q == ST_DEAD && fresh_q |=> tmr_q == $past(dead_rd)) // [R1]
		else $error("dead time not loaded for shot");
	chk_zero_dead: assert property (s_zero_dead |=> state_q != ST_DEAD) // [R12]
		else $error("zero dead time did not expire at once");
endmodule : bars_sequencer
`default_nettype wire

/* File: verilog/bars_shot_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module bars_shot_mem #(
	parameter int W = 17,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [W-1:0] wdata,
	input wire logic [$clog2(DEPTH)-1:0] raddr_a,
	output logic [W-1:0] rdata_a,
	input wire logic [$clog2(DEPTH)-1:0] raddr_b,
	output logic [W-1:0] rdata_b
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];

	for (genvar i = 0; i < DEPTH; i++) begin : g_word
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_q[i] <= '0;
			end else if (we && waddr == AW'(i)) begin
				mem_q[i] <= wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_a <= '0;
			rdata_b <= '0;
		end else begin
			rdata_a <= mem_q[raddr_a];
			rdata_b <= mem_q[raddr_b];
		end
	end
endmodule : bars_shot_mem
`default_nettype wire
